// file: pkg/serdes_lane3_params.svh
// Constants of the lane 3 SerDes configuration register bank.
`ifndef SERDES_LANE3_PARAMS_SVH
`define SERDES_LANE3_PARAMS_SVH

`define LANE_PORTS         4
`define CFG_PORT0_ADDR     32'h0001_30BC
`define CFG_PORT2_ADDR     32'h0001_32BC
`define CFG_PORT4_ADDR     32'h0001_34BC
`define CFG_PORT6_ADDR     32'h0001_36BC
`define CFG_RESET          32'h043C_E513

// Positions below are counted from the LSB; field bit n sits at 31-n.
`define HALF_RATE_BIT      31
`define RECALC_BIT         30
`define SPARE_HI           29
`define SPARE_LO           24
`define ZERO_BIT           23
`define TX_POWER_HI        22
`define TX_POWER_LO        20
`define TX_BOOST_HI        19
`define TX_BOOST_LO        16
`define RX_PLL_POWER_BIT   15
`define RX_ENABLE_BIT      14
`define DPLL_CLEAR_BIT     13
`define EQ_LEVEL_HI        10
`define EQ_LEVEL_LO        8
`define DPLL_SEL_HI        7
`define DPLL_SEL_LO        5
`define TX_DOMAIN_CLK_BIT  4
`define LOSS_FILTER_HI     3
`define LOSS_FILTER_LO     2
`define WORD_ALIGN_BIT     1

`define GUARDED_MASK       32'h8070_C000
`define ZERO_MASK          32'h0080_0000

`endif

// file: pkg/serdes_lane3_pkg.sv
// Types shared by the lane 3 SerDes configuration register bank.
package serdes_lane3_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic       half_rate;
      logic       tx_recalc_trigger;
      logic       dpll_freq_clear;
      logic [2:0] tx_power;
      logic [3:0] tx_boost;
      logic       rx_pll_power;
      logic       rx_out_enable;
      logic [2:0] rx_equalizer_level;
      logic [2:0] rx_dpll_select;
      logic       tx_domain_clock_on;
      logic [1:0] signal_loss_filter;
      logic       word_align_on;
   } lane_ctrl_t;

   typedef enum logic [0:0] {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_phase_t;

endpackage

// file: design/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       pce,
   input  wire logic [3:0] pin_in,
   output var  logic [3:0] level_out
);

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] level;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   // The first stage feeds only the second; the level moves only
   // when the two later stages agree, which hides a metastable hop.
   always_comb begin
      d = q;
      if (pce) begin
         d.s1 = pin_in;
         d.s2 = q.s1;
         d.s3 = q.s2;
         for (int i = 0; i < 4; i++) begin
            if (q.s2[i] == q.s3[i]) begin
               d.level[i] = q.s2[i];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level_out = q.level;

endmodule // pin_sync3

`default_nettype wire

// file: design/serdes_lane3_cfg.sv
// APB register bank for lane 3 SerDes configuration of four ports.
`timescale 1ns/1ps
`default_nettype none
`include "serdes_lane3_params.svh"

module serdes_lane3_cfg
   import serdes_lane3_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             pce,
   input  wire apb_req_t         apb_req,
   output var  apb_rsp_t         apb_rsp,
   input  wire logic [3:0]       init_override,
   input  wire logic [3:0]       speed_half_rate,
   input  wire logic [3:0]       rx_pll_locked_pin,
   output var  lane_ctrl_t [3:0] lane_ctrl
);

   typedef struct packed {
      bus_phase_t             phase;
      apb_rsp_t               rsp;
      logic [3:0][31:0]       cfg;
      lane_ctrl_t [3:0]       ctrl;
   } bank_state_t;

   bank_state_t q;
   bank_state_t d;
   logic [3:0]  pll_locked;

   // --------------------------------------------------------------
   // Lock indication crossing
   // --------------------------------------------------------------
   pin_sync3 u_lock_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pce       (pce),
      .pin_in    (rx_pll_locked_pin),
      .level_out (pll_locked)
   );

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   // Returns a one-hot port select; zero means unmapped.
   function automatic logic [3:0] decode_port(input logic [31:0] addr);
      logic [3:0] sel;
      sel = 4'h0;
      case (addr)
         `CFG_PORT0_ADDR: sel = 4'h1;
         `CFG_PORT2_ADDR: sel = 4'h2;
         `CFG_PORT4_ADDR: sel = 4'h4;
         `CFG_PORT6_ADDR: sel = 4'h8;
         default:         sel = 4'h0;
      endcase
      return sel;
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   // Software view of one register; the zero bit never reads back.
   function automatic logic [31:0] read_view(input logic [31:0] r);
      return r & ~`ZERO_MASK;
   endfunction

   // Merge a write into a stored word, honouring byte strobes and
   // the fields that only the override opens to software.
   function automatic logic [31:0] merge_write(
      input logic [31:0] old_v,
      input logic [31:0] wdata,
      input logic [3:0]  strb,
      input logic        override
   );
      logic [31:0] m;
      m = lane_mask(strb);
      if (!override) begin
         m = m & ~`GUARDED_MASK;
      end
      m = m & ~`ZERO_MASK;
      return (old_v & ~m) | (wdata & m);
   endfunction

   // Field view for the analog lane; the recalc and DPLL clear bits each give one rising-edge pulse.
   function automatic lane_ctrl_t build_ctrl(
      input logic [31:0] now_v,
      input logic [31:0] was_v,
      input logic        locked
   );
      lane_ctrl_t c;
      c = '0;
      c.half_rate          = now_v[`HALF_RATE_BIT];
      c.tx_recalc_trigger  = now_v[`RECALC_BIT] &
                             ~was_v[`RECALC_BIT];
      c.dpll_freq_clear    = now_v[`DPLL_CLEAR_BIT] &
                             ~was_v[`DPLL_CLEAR_BIT];
      c.tx_power           = now_v[`TX_POWER_HI:`TX_POWER_LO];
      c.tx_boost           = now_v[`TX_BOOST_HI:`TX_BOOST_LO];
      c.rx_pll_power       = now_v[`RX_PLL_POWER_BIT];
      c.rx_out_enable      = now_v[`RX_ENABLE_BIT] &
                             now_v[`RX_PLL_POWER_BIT] &
                             locked;
      c.rx_equalizer_level = now_v[`EQ_LEVEL_HI:`EQ_LEVEL_LO];
      c.rx_dpll_select     = now_v[`DPLL_SEL_HI:`DPLL_SEL_LO];
      c.tx_domain_clock_on = now_v[`TX_DOMAIN_CLK_BIT];
      c.signal_loss_filter =
         now_v[`LOSS_FILTER_HI:`LOSS_FILTER_LO];
      c.word_align_on      = now_v[`WORD_ALIGN_BIT];
      return c;
   endfunction

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   // Every access answers in the second access cycle, so pready and
   // prdata can both come from flip-flops.
   always_comb begin
      logic [3:0] sel;
      logic       access;
      sel    = 4'h0;
      access = 1'b0;
      d      = q;
      if (pce) begin
         sel    = decode_port(apb_req.paddr);
         access = apb_req.psel & apb_req.penable;
         d.rsp.pready  = 1'b0;
         d.rsp.pslverr = 1'b0;
         d.rsp.prdata  = '0;
         case (q.phase)
            BUS_IDLE: begin
               if (access) begin
                  d.phase       = BUS_ANSWER;
                  d.rsp.pready  = 1'b1;
                  d.rsp.pslverr = (sel == 4'h0);
                  for (int p = 0; p < `LANE_PORTS; p++) begin
                     if (sel[p] && !apb_req.pwrite) begin
                        d.rsp.prdata = read_view(q.cfg[p]);
                     end
                  end
               end
            end
            BUS_ANSWER: begin
               // The write lands on the edge that sees pready high.
               d.phase = BUS_IDLE;
               if (access && apb_req.pwrite) begin
                  for (int p = 0; p < `LANE_PORTS; p++) begin
                     if (sel[p]) begin
                        d.cfg[p] = merge_write(q.cfg[p],
                                               apb_req.pwdata,
                                               apb_req.pstrb,
                                               init_override[p]);
                     end
                  end
               end
            end
            default: begin
               d.phase = BUS_IDLE;
            end
         endcase
         // Without override the rate bit tracks the speed divider, so
         // a stray write cannot leave lane and PLL disagreeing.
         for (int p = 0; p < `LANE_PORTS; p++) begin
            if (!init_override[p]) begin
               d.cfg[p][`HALF_RATE_BIT] = speed_half_rate[p];
            end
            d.ctrl[p] = build_ctrl(d.cfg[p], q.cfg[p], pll_locked[p]);
         end
      end
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.phase <= BUS_IDLE;
         q.rsp   <= '0;
         for (int p = 0; p < `LANE_PORTS; p++) begin
            q.cfg[p]  <= `CFG_RESET;
            q.ctrl[p] <= '0;
         end
      end else begin
         q <= d;
      end
   end

   assign apb_rsp   = q.rsp;
   assign lane_ctrl = q.ctrl;

endmodule // serdes_lane3_cfg

`default_nettype wire

// file: sim/cfg_monitor.sv
// Port checker of the lane 3 SerDes configuration bank.
`timescale 1ns/1ps
`default_nettype none

module cfg_monitor
   import serdes_lane3_pkg::*;
(
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             pce,
   input wire apb_req_t         apb_req,
   input wire apb_rsp_t         apb_rsp,
   input wire logic [3:0]       init_override,
   input wire logic [3:0]       speed_half_rate,
   input wire logic [3:0]       rx_pll_locked_pin,
   input wire lane_ctrl_t [3:0] lane_ctrl
);
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // The bench keeps pce high during transfers, so the answer must
   // follow at once.
   AST_READY: assert property (
      apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
      else $error("pready missing after access");
   AST_ERR_ZERO: assert property (
      apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("error answer malformed");
   AST_BIT8_ZERO: assert property (
      apb_rsp.pready && !apb_req.pwrite |-> !apb_rsp.prdata[23])
      else $error("reserved bit read as one");
   AST_RECALC_PULSE: assert property (
      lane_ctrl[1].tx_recalc_trigger |=> !lane_ctrl[1].tx_recalc_trigger)
      else $error("recalc pulse too long");
   AST_CLEAR_PULSE: assert property (
      lane_ctrl[1].dpll_freq_clear |=> !lane_ctrl[1].dpll_freq_clear)
      else $error("clear pulse too long");
   AST_RX_GATE: assert property (
      (!rx_pll_locked_pin[1] && pce) [*8] |-> !lane_ctrl[1].rx_out_enable)
      else $error("receive enabled without lock");
   AST_GUARD: assert property (
      (presetn && !init_override[0]) [*2] |-> lane_ctrl[0].tx_power == 3'h3
         && lane_ctrl[0].rx_pll_power)
      else $error("guarded field changed");
   AST_HALF: assert property (
      (!init_override[0] && $stable(speed_half_rate[0])) [*4]
         |-> lane_ctrl[0].half_rate == speed_half_rate[0])
      else $error("half rate not following speed");
endmodule // cfg_monitor

`default_nettype wire

// file: sim/tb.sv
// Testbench of the lane 3 SerDes configuration bank.
`timescale 1ns/1ps
`default_nettype none
`include "serdes_lane3_params.svh"

module tb import serdes_lane3_pkg::*;;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic        err;
   } row_t;
   // Writable bits when not overridden, and what guarded bits keep.
   localparam logic [31:0] KEEP = ~(`GUARDED_MASK | `ZERO_MASK);
   localparam logic [31:0] RG   = `CFG_RESET & `GUARDED_MASK;
   logic             pclk = 1'b0;
   logic             presetn = 1'b0;
   apb_req_t         req = '0;
   apb_rsp_t         rsp;
   logic [3:0]       spd = 4'h0;
   logic [3:0]       lock = 4'h0;
   logic             ce = 1'b1;
   logic [3:0]       ovr = 4'h2;
   lane_ctrl_t [3:0] lc;
   lane_ctrl_t       elc;
   logic [31:0]      rd;
   logic             er;
   int               num_errors = 0;
   int               total_checks = 0;
   int               a;
   int               b;
   row_t             rows [5];

   serdes_lane3_cfg i_dut (.pclk, .presetn, .pce(ce), .apb_req(req),
      .apb_rsp(rsp), .init_override(ovr), .speed_half_rate(spd),
      .rx_pll_locked_pin(lock), .lane_ctrl(lc));

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] ad,
                      input logic [31:0] d);
      int k;
      // Request and answer both change on rising edges only, so the
      // answer is taken at the very edge that sees pready high.
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, ad, d, 4'hF};
      @(posedge pclk);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         num_errors++;
         complete_run();
      end
      rd = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
   endtask

   // Counts pulses on lane 1 over the cycles after a write.
   task automatic pulses(input logic [31:0] d);
      apb(1'b1, `CFG_PORT2_ADDR, d);
      a = 0;
      b = 0;
      repeat (6) begin
         @(negedge pclk);
         a += int'(lc[1].tx_recalc_trigger);
         b += int'(lc[1].dpll_freq_clear);
      end
   endtask

   // -----------------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------------
   initial begin
      rows = '{'{`CFG_PORT0_ADDR, 32'hFFFF_FFFF, KEEP | RG, 1'b0},
         '{`CFG_PORT2_ADDR, 32'hFFFF_FFFF, ~`ZERO_MASK, 1'b0},
         '{`CFG_PORT4_ADDR, 32'h0000_0001, RG | 32'h0000_0001, 1'b0},
         '{`CFG_PORT6_ADDR, 32'h5A5A_A5A5, (32'h5A5A_A5A5 & KEEP) | RG, 1'b0},
         '{32'h0001_30C0, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
      repeat (10) @(posedge pclk);
      chk("lane reset", 32'h0, 32'(lc));
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, rows[i].addr, 32'h0);
         chk("reset value", `CFG_RESET, rd);
      end
      $display("reset values done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].addr, rows[i].wdata);
         chk("write err", 32'(rows[i].err), 32'(er));
         apb(1'b0, rows[i].addr, 32'h0);
         chk("readback", rows[i].exp, rd);
         chk("read err", 32'(rows[i].err), 32'(er));
      end
      $display("row table done");
      elc = '{1'b1, 1'b0, 1'b0, 3'h7, 4'hF, 1'b1, 1'b0, 3'h7, 3'h7, 1'b1,
              2'h3, 1'b1};
      chk("lane fields", 32'(elc), 32'(lc[1]));
      lock <= 4'h2;
      repeat (8) @(posedge pclk);
      chk("rx enable", 32'h1, 32'(lc[1].rx_out_enable));
      pulses(32'hFF7F_BFFF);
      chk("rx disable", 32'h0, 32'(lc[1].rx_out_enable));
      $display("receive enable done");
      pulses(32'hBF7F_DFFF);
      chk("no rise", 32'h0, 32'(a + b));
      pulses(32'hFF7F_FFFF);
      chk("recalc", 32'h1, 32'(a));
      chk("dpll clear", 32'h1, 32'(b));
      pulses(32'hFF7F_FFFF);
      chk("held bits", 32'h0, 32'(a + b));
      $display("pulse test done");
      // A low clock enable must hold even the lock synchroniser.
      @(posedge pclk);
      ce <= 1'b0;
      lock <= 4'h0;
      repeat (10) @(posedge pclk);
      chk("frozen enable", 32'h1, 32'(lc[1].rx_out_enable));
      ce <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("lock lost", 32'h0, 32'(lc[1].rx_out_enable));
      $display("clock enable done");
      spd <= 4'h1;
      repeat (6) @(posedge pclk);
      apb(1'b0, `CFG_PORT0_ADDR, 32'h0);
      chk("half rate", KEEP | RG | 32'h8000_0000, rd);
      chk("half out", 32'h1, 32'(lc[0].half_rate));
      $display("half rate done");
      ovr <= 4'h3;
      apb(1'b1, `CFG_PORT0_ADDR, 32'h8000_0001);
      apb(1'b0, `CFG_PORT0_ADDR, 32'h0);
      chk("override write", 32'h8000_0001, rd);
      chk("ovr tx power", 32'h0, 32'(lc[0].tx_power));
      chk("ovr pll power", 32'h0, 32'(lc[0].rx_pll_power));
      $display("override done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CFG_PORT2_ADDR, 32'h0);
      chk("second reset", `CFG_RESET, rd);
      $display("second reset done");
      complete_run();
   end
endmodule // tb

bind serdes_lane3_cfg cfg_monitor i_mon (.pclk, .presetn, .pce, .apb_req,
   .apb_rsp, .init_override, .speed_half_rate, .rx_pll_locked_pin,
   .lane_ctrl);

`default_nettype wire
